//--- pkg/eac_pkg.sv
package eac_pkg;

  // ----------------------------------------------------------------
  // register offsets in i/o space
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CONTROL = 6'h1c;
  localparam logic [5:0] OFS_DATA = 6'h1d;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h1e;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h1f;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_WRITE_ARM = 2;
  localparam int BIT_READY_IRQ_EN = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // array geometry and timing
  // ----------------------------------------------------------------
  localparam int NVM_ADDR_W = 9;
  localparam int NVM_DEPTH = 512;
  localparam int ARM_CYCLES = 4;
  localparam int WRITE_HALT_CYCLES = 4;
  localparam int READ_HALT_CYCLES = 2;
  localparam int WRITE_OSC_CYCLES = 2048;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] ARM_CNT_INIT = CNT_W'(ARM_CYCLES);
  localparam logic [CNT_W-1:0] WHALT_INIT = CNT_W'(WRITE_HALT_CYCLES - 1);
  localparam logic [CNT_W-1:0] RHALT_INIT = CNT_W'(READ_HALT_CYCLES - 1);

endpackage : eac_pkg

//--- pkg/eac_nvm_if.sv
`timescale 1ns/10ps
interface eac_nvm_if;
  import eac_pkg::*;

  logic start_write;
  logic start_read;
  logic [NVM_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic osc_tick;
  logic [7:0] rdata;
  logic read_done;
  logic write_done;

  modport ctrl (
    output start_write,
    output start_read,
    output addr,
    output wdata,
    output osc_tick,
    input rdata,
    input read_done,
    input write_done
  );

  modport core (
    input start_write,
    input start_read,
    input addr,
    input wdata,
    input osc_tick,
    output rdata,
    output read_done,
    output write_done
  );
endinterface : eac_nvm_if

//--- src/eac_nvm_core.sv
`timescale 1ns/10ps
module eac_nvm_core #(
  parameter int DEPTH = eac_pkg::NVM_DEPTH,
  parameter int OSC_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  eac_nvm_if.core nvm
);
  import eac_pkg::*;

  localparam int TW = $clog2(OSC_CYCLES + 1);

  logic [7:0] mem [DEPTH];
  logic busy_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic [NVM_ADDR_W-1:0] waddr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic read_done_reg;
  logic write_done_reg;

  assign nvm.rdata = rdata_reg;
  assign nvm.read_done = read_done_reg;
  assign nvm.write_done = write_done_reg;

  // ----------------------------------------------------------------
  // self-timed write, counted on oscillator ticks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    write_done_reg <= 1'b0;
    if (reset)
    begin
      busy_reg <= 1'b0;
      tick_cnt_reg <= '0;
    end
    else if (!busy_reg && nvm.start_write)
    begin
      busy_reg <= 1'b1;
      tick_cnt_reg <= TW'(OSC_CYCLES);
      waddr_reg <= nvm.addr;
      wdata_reg <= nvm.wdata;
    end
    else if (busy_reg && nvm.osc_tick)
    begin
      if (tick_cnt_reg == TW'(1))
      begin
        busy_reg <= 1'b0;
        write_done_reg <= 1'b1; // RULE6
      end
      tick_cnt_reg <= tick_cnt_reg - TW'(1); // RULE6
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (busy_reg && nvm.osc_tick && tick_cnt_reg == TW'(1))
    begin
      mem[waddr_reg] <= wdata_reg; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // single-cycle read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      read_done_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      read_done_reg <= nvm.start_read && !read_done_reg;
      if (nvm.start_read && !read_done_reg)
      begin
        rdata_reg <= mem[nvm.addr]; // RULE1
      end
    end
  end

endmodule : eac_nvm_core

//--- src/eac_top.sv
`timescale 1ns/10ps
// Functional notes
// RULE1: array is 512 bytes, 9-bit linear address; higher bits read zero.
// RULE2: address is undefined after reset; software loads it before access.
// RULE3: data register feeds writes and receives read bytes.
// RULE4: write-arm bit clears itself four clock cycles after being set.
// RULE5: write strobe starts a write only while write-arm is one.
// RULE6: write lasts 2048 oscillator cycles, then write strobe clears.
// RULE7: setting write strobe halts the core for four cycles.
// RULE8: read strobe loads data register promptly, then clears itself.
// RULE9: setting read strobe halts the core for two cycles.
// RULE10: during a write, read strobe and address writes are ignored.
// RULE11: ready interrupt stays asserted while enabled and write strobe zero.
// RULE12: software arms, then strobes within four cycles, after idle check.
// RULE13: software should keep interrupts off between arming and strobing; nvm_write arms with the ready enable on and global_irq_en high.
// RULE14: software polls write strobe to zero before starting a read.
// RULE15: control bits 7..4 read zero; control bits reset to zero.
module eac_top #(
  parameter int DEPTH = eac_pkg::NVM_DEPTH,
  parameter int OSC_CYCLES = eac_pkg::WRITE_OSC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  input wire logic osc_tick,
  input wire logic global_irq_en,
  output logic ready_irq,
  output logic cpu_halt
);
  import eac_pkg::*;

  typedef enum logic [2:0]
  {
    ACC_IDLE = 3'b001,
    ACC_READ = 3'b010,
    ACC_WRITE = 3'b100
  } eac_acc_state_t;

  logic ready_irq_en_reg;
  logic write_arm_reg;
  logic write_strobe_reg;
  logic read_strobe_reg;
  logic [CNT_W-1:0] arm_cnt_reg;
  logic [CNT_W-1:0] halt_cnt_reg;
  logic [NVM_ADDR_W-1:0] nvm_address_reg;
  logic [7:0] nvm_data_reg;
  logic [7:0] io_rdata_reg;
  logic ready_irq_reg;
  logic cpu_halt_reg;
  logic [7:0] control_view;
  logic ctl_we;
  logic write_accept;
  logic read_accept;
  eac_acc_state_t acc_state_reg;
  logic start_write_reg;
  logic start_read_reg;

  eac_nvm_if nvm ();

  eac_nvm_core #(
    .DEPTH(DEPTH),
    .OSC_CYCLES(OSC_CYCLES)
  ) u_core (
    .clk_sys(clk_sys),
    .reset(reset),
    .nvm(nvm)
  );

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign ctl_we = io_we && io_addr == OFS_CONTROL;
  assign write_accept = ctl_we && io_wdata[BIT_WRITE_STROBE]
    && write_arm_reg && acc_state_reg == ACC_IDLE; // RULE5
  assign read_accept = ctl_we && io_wdata[BIT_READ_STROBE]
    && !write_accept && acc_state_reg == ACC_IDLE; // RULE10

  assign nvm.start_write = start_write_reg;
  assign nvm.start_read = start_read_reg;
  assign nvm.addr = nvm_address_reg;
  assign nvm.wdata = nvm_data_reg;
  assign nvm.osc_tick = osc_tick;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // one access at a time, so a finished write is never started again
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      acc_state_reg <= ACC_IDLE;
    end
    else
    begin
      unique case (acc_state_reg)
        ACC_IDLE:
        begin
          if (write_accept)
          begin
            acc_state_reg <= ACC_WRITE; // RULE5
          end
          else if (read_accept)
          begin
            acc_state_reg <= ACC_READ; // RULE8
          end
        end
        ACC_READ:
        begin
          if (nvm.read_done)
          begin
            acc_state_reg <= ACC_IDLE;
          end
        end
        ACC_WRITE:
        begin
          if (nvm.write_done)
          begin
            acc_state_reg <= ACC_IDLE; // RULE6
          end
        end
        default:
        begin
          acc_state_reg <= ACC_IDLE;
        end
      endcase
    end
  end

  // single start pulse to the core per accepted access
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      start_write_reg <= 1'b0;
      start_read_reg <= 1'b0;
    end
    else
    begin
      start_write_reg <= write_accept;
      start_read_reg <= read_accept;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ready_irq_en_reg <= CONTROL_RESET[BIT_READY_IRQ_EN]; // RULE15
    end
    else if (ctl_we)
    begin
      ready_irq_en_reg <= io_wdata[BIT_READY_IRQ_EN];
    end
  end

  // write-arm window
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      write_arm_reg <= CONTROL_RESET[BIT_WRITE_ARM]; // RULE15
      arm_cnt_reg <= '0;
    end
    else if (ctl_we && io_wdata[BIT_WRITE_ARM])
    begin
      write_arm_reg <= 1'b1;
      arm_cnt_reg <= ARM_CNT_INIT; // RULE4
    end
    else if (ctl_we)
    begin
      write_arm_reg <= 1'b0;
      arm_cnt_reg <= '0;
    end
    else if (arm_cnt_reg != '0)
    begin
      arm_cnt_reg <= arm_cnt_reg - CNT_W'(1);
      if (arm_cnt_reg == CNT_W'(1))
      begin
        write_arm_reg <= 1'b0; // RULE4
      end
    end
  end

  // write strobe: set by accepted start, cleared by the core's completion
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      write_strobe_reg <= CONTROL_RESET[BIT_WRITE_STROBE]; // RULE15
    end
    else if (write_accept)
    begin
      write_strobe_reg <= 1'b1; // RULE5
    end
    else if (nvm.write_done)
    begin
      write_strobe_reg <= 1'b0; // RULE6
    end
  end

  // read strobe: cleared once the byte has landed
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      read_strobe_reg <= CONTROL_RESET[BIT_READ_STROBE]; // RULE15
    end
    else if (read_accept)
    begin
      read_strobe_reg <= 1'b1;
    end
    else if (nvm.read_done)
    begin
      read_strobe_reg <= 1'b0; // RULE8
    end
  end

  // ----------------------------------------------------------------
  // address and data registers
  // ----------------------------------------------------------------
  // address is left without reset on purpose: it is undefined after reset
  always_ff @(posedge clk_sys)
  begin
    if (io_we && !write_strobe_reg) // RULE10
    begin
      if (io_addr == OFS_ADDR_LOW)
      begin
        nvm_address_reg[7:0] <= io_wdata; // RULE2
      end
      else if (io_addr == OFS_ADDR_HIGH)
      begin
        nvm_address_reg[8] <= io_wdata[0]; // RULE1
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      nvm_data_reg <= 8'h00;
    end
    else if (nvm.read_done)
    begin
      nvm_data_reg <= nvm.rdata; // RULE3 RULE8
    end
    else if (io_we && io_addr == OFS_DATA)
    begin
      nvm_data_reg <= io_wdata; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // core halt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cpu_halt_reg <= 1'b0;
      halt_cnt_reg <= '0;
    end
    else if (write_accept)
    begin
      cpu_halt_reg <= 1'b1;
      halt_cnt_reg <= WHALT_INIT; // RULE7
    end
    else if (read_accept)
    begin
      cpu_halt_reg <= 1'b1;
      halt_cnt_reg <= RHALT_INIT; // RULE9
    end
    else if (halt_cnt_reg != '0)
    begin
      halt_cnt_reg <= halt_cnt_reg - CNT_W'(1);
    end
    else
    begin
      cpu_halt_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ready interrupt and read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ready_irq_reg <= 1'b0;
    end
    else
    begin
      ready_irq_reg <= ready_irq_en_reg && global_irq_en
        && !write_strobe_reg; // RULE11
    end
  end

  assign control_view = {4'h0, ready_irq_en_reg, write_arm_reg,
    write_strobe_reg, read_strobe_reg}; // RULE15

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      io_rdata_reg <= 8'h00;
    end
    else if (io_re)
    begin
      unique case (io_addr)
        OFS_CONTROL: io_rdata_reg <= control_view;
        OFS_DATA: io_rdata_reg <= nvm_data_reg;
        OFS_ADDR_LOW: io_rdata_reg <= nvm_address_reg[7:0];
        OFS_ADDR_HIGH: io_rdata_reg <= {7'h00, nvm_address_reg[8]}; // RULE1
        default: io_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign io_rdata = io_rdata_reg;
  assign ready_irq = ready_irq_reg;
  assign cpu_halt = cpu_halt_reg;

endmodule : eac_top

//--- sim/eac_core_model.sv
`timescale 1ns/10ps
module eac_core_model (
  input wire logic clk_sys,
  input wire logic cpu_halt,
  input wire logic [7:0] io_rdata,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re
);
  import eac_pkg::*;
  logic idle_late = 1'b0;
  // ----
  // processor core bus cycles, stalled while halted
  // ----
  initial
  begin
    io_addr = 6'h00;
    io_wdata = 8'h00;
    io_we = 1'b0;
    io_re = 1'b0;
  end
  task automatic go();
    @(negedge clk_sys);
    while (cpu_halt)
      @(negedge clk_sys);
  endtask : go
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    go();
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(negedge clk_sys);
    io_we = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    go();
    io_addr = a;
    io_re = 1'b1;
    @(negedge clk_sys);
    io_re = 1'b0;
    d = io_rdata;
  endtask : rd
  task automatic wait_idle();
    logic [7:0] c;
    c = 8'h02;
    for (int i = 0; i < 100 && c[BIT_WRITE_STROBE]; i++)
      rd(OFS_CONTROL, c);
    if (c[BIT_WRITE_STROBE])
      idle_late = 1'b1;
  endtask : wait_idle
  task automatic set_addr(input logic [8:0] a);
    wait_idle();
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_ADDR_HIGH, {7'h00, a[8]});
  endtask : set_addr
  task automatic nvm_write(input logic [8:0] a, input logic [7:0] d);
    set_addr(a);
    wr(OFS_DATA, d);
    wr(OFS_CONTROL, 8'h0c);
    wr(OFS_CONTROL, 8'h0a);
    wait_idle();
  endtask : nvm_write
  task automatic nvm_read(input logic [8:0] a, output logic [7:0] d);
    set_addr(a);
    wr(OFS_CONTROL, 8'h09);
    rd(OFS_DATA, d);
  endtask : nvm_read
endmodule : eac_core_model

//--- sim/eac_top_chk.sv
`timescale 1ns/10ps
module eac_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_rdata,
  input wire logic osc_tick,
  input wire logic global_irq_en,
  input wire logic ready_irq,
  input wire logic cpu_halt
);
  import eac_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic [2:0] arm_cnt;
  logic en_sh;
  logic ctl_we;
  logic go_w;
  logic go_r;
  assign ctl_we = io_we && io_addr == OFS_CONTROL;
  assign go_w = ctl_we && io_wdata[BIT_WRITE_STROBE] && ready_irq && !cpu_halt;
  assign go_r = ctl_we && io_wdata[BIT_READ_STROBE] && ready_irq && !cpu_halt;
  // ----
  // shadow of arm window and interrupt enable
  // ----
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      arm_cnt <= 3'h0;
    else if (ctl_we)
      arm_cnt <= io_wdata[BIT_WRITE_ARM] ? 3'h4 : 3'h0;
    else if (arm_cnt != 3'h0)
      arm_cnt <= arm_cnt - 3'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      en_sh <= 1'b0;
    else if (ctl_we)
      en_sh <= io_wdata[BIT_READY_IRQ_EN];
  end
  sequence s_halt4;
    cpu_halt [*4] ##1 !cpu_halt;
  endsequence
  sequence s_halt2;
    cpu_halt [*2] ##1 !cpu_halt;
  endsequence
  a_write_halt: assert property (go_w && arm_cnt != 3'h0 |=> s_halt4)
    else $error("write halt wrong");
  a_irq_drop: assert property (go_w && arm_cnt != 3'h0 |=> ##1 !ready_irq)
    else $error("irq not dropped on write");
  a_unarmed_none: assert property (go_w && arm_cnt == 3'h0 |=> !cpu_halt [*2])
    else $error("unarmed strobe acted");
  a_read_halt: assert property (go_r |=> s_halt2)
    else $error("read halt wrong");
  a_busy_noread: assert property (ctl_we && io_wdata[BIT_READ_STROBE]
    && !ready_irq && !cpu_halt && $past(en_sh) && $past(global_irq_en)
    |=> !cpu_halt)
    else $error("read started during write");
  a_irq_off: assert property (!en_sh || !global_irq_en |=> !ready_irq)
    else $error("irq while disabled");
  a_rdata_hold: assert property (!io_re |=> $stable(io_rdata))
    else $error("read data moved");
  a_ctl_upper: assert property (io_re && io_addr == OFS_CONTROL
    |=> io_rdata[7:4] == 4'h0)
    else $error("control upper bits set");
  a_high_zero: assert property (io_re && io_addr == OFS_ADDR_HIGH
    |=> io_rdata[7:1] == 7'h00)
    else $error("address high upper bits set");
endmodule : eac_chk
bind eac_top eac_chk chk_u (.clk_sys(clk_sys), .reset(reset),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
  .io_rdata(io_rdata), .osc_tick(osc_tick), .global_irq_en(global_irq_en),
  .ready_irq(ready_irq), .cpu_halt(cpu_halt));

//--- sim/eac_top_test.sv
`timescale 1ns/10ps
module eac_top_test;
  import eac_pkg::*;
  typedef struct packed {logic [8:0] a; logic [7:0] d;} eac_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic osc_tick = 1'b0;
  logic global_irq_en = 1'b1;
  logic [1:0] tdiv = 2'h0;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [7:0] v;
  logic io_we;
  logic io_re;
  logic ready_irq;
  logic cpu_halt;
  int error_cnt = 0;
  int n_compared = 0;
  eac_row_t rows [4] = '{'{9'h000, 8'h5a}, '{9'h1ff, 8'ha5},
    '{9'h100, 8'h3c}, '{9'h0ff, 8'hc3}};
  always #5 clk_sys = ~clk_sys;
  // oscillator tick every fourth clock
  always @(negedge clk_sys)
  begin
    tdiv <= tdiv + 2'h1;
    osc_tick <= tdiv == 2'h3;
  end
  eac_top #(.OSC_CYCLES(8)) dut_u (.clk_sys(clk_sys), .reset(reset),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata(io_rdata), .osc_tick(osc_tick), .global_irq_en(global_irq_en),
    .ready_irq(ready_irq), .cpu_halt(cpu_halt));
  eac_core_model core_u (.clk_sys(clk_sys), .cpu_halt(cpu_halt),
    .io_rdata(io_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_we(io_we), .io_re(io_re));
  task automatic chk(input string nm, input logic [7:0] got,
    input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    foreach (rows[i])
      core_u.nvm_write(rows[i].a, rows[i].d);
    foreach (rows[i])
    begin
      core_u.nvm_read(rows[i].a, v);
      chk("array", v, rows[i].d);
    end
    core_u.wr(OFS_CONTROL, 8'hf8);
    core_u.rd(OFS_CONTROL, v);
    chk("control", v, 8'h08);
    chk("irq_on", {7'h00, ready_irq}, 8'h01);
    global_irq_en = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("irq_gie", {7'h00, ready_irq}, 8'h00);
    global_irq_en = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("irq_back", {7'h00, ready_irq}, 8'h01);
    core_u.wr(OFS_ADDR_HIGH, 8'hff);
    core_u.rd(OFS_ADDR_HIGH, v);
    chk("addr_high", v, 8'h01);
    core_u.rd(6'h00, v);
    chk("unmapped", v, 8'h00);
    core_u.wr(OFS_CONTROL, 8'h00);
    @(negedge clk_sys);
    chk("irq_off", {7'h00, ready_irq}, 8'h00);
    // arm window lapses before the strobe
    core_u.nvm_write(9'h010, 8'h11);
    core_u.wr(OFS_DATA, 8'h77);
    core_u.wr(OFS_CONTROL, 8'h0c);
    repeat (3) @(negedge clk_sys);
    core_u.wr(OFS_CONTROL, 8'h0a);
    core_u.rd(OFS_CONTROL, v);
    chk("late_strobe", v, 8'h08);
    core_u.nvm_read(9'h010, v);
    chk("late_data", v, 8'h11);
    // strobe on the last cycle of the arm window
    core_u.wr(OFS_DATA, 8'h66);
    core_u.wr(OFS_CONTROL, 8'h0c);
    repeat (2) @(negedge clk_sys);
    core_u.wr(OFS_CONTROL, 8'h0a);
    chk("halt_w", {7'h00, cpu_halt}, 8'h01);
    core_u.nvm_read(9'h010, v);
    chk("edge_data", v, 8'h66);
    // address and read attempts while writing
    core_u.wr(OFS_ADDR_LOW, 8'h20);
    core_u.wr(OFS_DATA, 8'h99);
    core_u.wr(OFS_CONTROL, 8'h0c);
    core_u.wr(OFS_CONTROL, 8'h0a);
    core_u.wr(OFS_ADDR_LOW, 8'h30);
    core_u.wr(OFS_CONTROL, 8'h09);
    core_u.rd(OFS_CONTROL, v);
    chk("busy_ctl", v, 8'h0a);
    core_u.rd(OFS_ADDR_LOW, v);
    chk("busy_addr", v, 8'h20);
    chk("busy_irq", {7'h00, ready_irq}, 8'h00);
    core_u.nvm_read(9'h020, v);
    chk("busy_data", v, 8'h99);
    reset = 1'b1;
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    core_u.rd(OFS_CONTROL, v);
    chk("rst_ctl", v, 8'h00);
    chk("rst_irq", {7'h00, ready_irq}, 8'h00);
    chk("rst_halt", {7'h00, cpu_halt}, 8'h00);
    core_u.nvm_read(9'h1ff, v);
    chk("kept", v, 8'ha5);
    chk("idle_wait", {7'h00, core_u.idle_late}, 8'h00);
    give_verdict();
  end
endmodule : eac_top_test
